// ===== rcfg_dev.sv
// reconfiguration controller for the analog front end of NCH channels
// assumes user logic on pclk drives the rcfg_if port; lock and channel-kind pins are async
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module rcfg_dev
	import rcfg_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	rcfg_if.dev                        rc,
	input  wire logic                  cru_locked_to_data,
	input  wire logic [NCH-1:0]        chan_tx_only,
	output logic [NCH*SWG_W-1:0]       afe_swing,
	output logic [NCH*PRE_W-1:0]       afe_preemph,
	output logic [NCH*EQ_W-1:0]        afe_eq,
	output logic [NCH*DCG_W-1:0]       afe_dcgain,
	output logic [NCH-1:0]             afe_rate_div
);

	// ****************************************
	// types and state
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_CANCEL = 2'b01,
		ST_XFER   = 2'b10
	} rcfg_st_t;

	rcfg_st_t               st_r;
	logic [CNT_W-1:0]       cnt_r;
	logic                   cancel_done_r;
	logic                   is_read_r;
	logic [1:0]             dup_r;
	logic [2:0]             op_r;
	logic                   dv_r;
	logic                   rej_r;
	logic [1:0]             lock_s_r;
	logic [NCH-1:0]         txo_s0_r;
	logic [NCH-1:0]         txo_s1_r;
	logic [NCH*SWG_W-1:0]   swg_r;
	logic [NCH*PRE_W-1:0]   pre_r;
	logic [NCH*EQ_W-1:0]    eq_r;
	logic [NCH*DCG_W-1:0]   dcg_r;
	logic [NCH-1:0]         rdv_r;
	logic [NCH*SWG_W-1:0]   swg_q_r;
	logic [NCH*PRE_W-1:0]   pre_q_r;
	logic [NCH*EQ_W-1:0]    eq_q_r;
	logic [NCH*DCG_W-1:0]   dcg_q_r;
	logic [NCH*SWG_W-1:0]   swg_o_r;
	logic [NCH*PRE_W-1:0]   pre_o_r;
	logic [NCH*EQ_W-1:0]    eq_o_r;
	logic [NCH*DCG_W-1:0]   dcg_o_r;
	logic [NCH-1:0]         rdv_q_r;
	logic                   req;
	logic                   supported;
	logic                   accept;
	logic                   done;

	// ****************************************
	// pin synchronisers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_s_r <= 2'b00;
			txo_s0_r <= '0;
			txo_s1_r <= '0;
		end else begin
			lock_s_r <= {lock_s_r[0], cru_locked_to_data};
			txo_s0_r <= chan_tx_only;
			txo_s1_r <= txo_s0_r;
		end
	end

	// high only while locked to data, low while on the reference clock
	assign rc.freq_locked = lock_s_r[1] & ~rc.rx_analog_reset;

	// ****************************************
	// request filter
	// ****************************************
	// a simultaneous read and write is not a request at all
	assign req = (rc.read ^ rc.write) & ~rc.powerdown;
	always_comb begin
		supported = 1'b0;
		case (rcfg_op_t'(rc.op))
			OP_ANALOG:   supported = 1'b1;
			OP_CHAN_IF:  supported = 1'b1;
			OP_RATE_DIV: supported = ~rc.read | 1'b1;
			default:     supported = 1'b0;
		endcase
		// rate division needs every targeted channel to own a receiver
		if (rcfg_op_t'(rc.op) == OP_RATE_DIV && rc.write &&
		    |(rc.rate_div_in & txo_s1_r)) begin
			supported = 1'b0;
		end
	end
	assign accept = (st_r == ST_IDLE) && cancel_done_r && req && supported;
	assign done   = (st_r != ST_IDLE) && (cnt_r == CNT_W'(BUSY_CYC - 1));

	// ****************************************
	// sequencer
	// ****************************************
	// the busy time is the shortened model figure, not the silicon duration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r          <= ST_IDLE;
			cnt_r         <= '0;
			cancel_done_r <= 1'b0;
			is_read_r     <= 1'b0;
			dup_r         <= DUP_RST;
			op_r          <= OP_ANALOG;
		end else begin
			case (st_r)
				ST_IDLE: begin
					cnt_r <= '0;
					if (!cancel_done_r && !rc.powerdown) begin
						st_r <= ST_CANCEL;
					end else if (accept) begin
						st_r      <= ST_XFER;
						is_read_r <= rc.read;
						dup_r     <= rc.duplex_sel;
						op_r      <= rc.op;
					end
				end
				ST_CANCEL: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (done) begin
						st_r          <= ST_IDLE;
						cancel_done_r <= 1'b1;
					end
				end
				ST_XFER: begin
					cnt_r <= cnt_r + CNT_W'(1);
					if (done) begin
						st_r <= ST_IDLE;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	assign rc.busy = (st_r != ST_IDLE);

	// ****************************************
	// status flags
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dv_r <= 1'b0;
		end else if (done && st_r == ST_XFER && is_read_r) begin
			dv_r <= 1'b1;
		end else if (accept) begin
			dv_r <= 1'b0;
		end
	end

	// an unsupported request raises rejected until the next accepted one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rej_r <= 1'b0;
		end else if (st_r == ST_IDLE && cancel_done_r && req && !supported) begin
			rej_r <= 1'b1;
		end else if (accept) begin
			rej_r <= 1'b0;
		end
	end

	assign rc.data_valid = dv_r;
	assign rc.rejected   = rej_r;

	// ****************************************
	// write data capture and settings store
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swg_q_r <= '0;
			pre_q_r <= '0;
			eq_q_r  <= '0;
			dcg_q_r <= '0;
			rdv_q_r <= '0;
		end else if (accept && rc.write) begin
			swg_q_r <= rc.swing_in;
			pre_q_r <= rc.preemph_in;
			eq_q_r  <= rc.eq_in;
			dcg_q_r <= rc.dcgain_in;
			rdv_q_r <= rc.rate_div_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swg_r <= '0;
			pre_r <= '0;
			eq_r  <= '0;
			dcg_r <= '0;
			rdv_r <= '0;
		end else if (done && st_r == ST_XFER && !is_read_r) begin
			case (rcfg_op_t'(op_r))
				OP_ANALOG: begin
					// duplex select picks which side of the front end changes
					if (dup_r[1]) begin
						swg_r <= swg_q_r;
						pre_r <= pre_q_r;
					end
					if (dup_r[0]) begin
						eq_r  <= eq_q_r;
						dcg_r <= dcg_q_r;
					end
				end
				// whole-channel mode leaves equalization alone
				OP_CHAN_IF: begin
					swg_r <= swg_q_r;
					pre_r <= pre_q_r;
					dcg_r <= dcg_q_r;
				end
				OP_RATE_DIV: rdv_r <= rdv_q_r;
				default: rdv_r <= rdv_r;
			endcase
		end
	end

	// ****************************************
	// readback buses
	// ****************************************
	// channel n occupies bits [n*3 +: 3] of the swing bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swg_o_r <= '0;
			pre_o_r <= '0;
			eq_o_r  <= '0;
			dcg_o_r <= '0;
		end else if (done && st_r == ST_XFER && is_read_r) begin
			if (dup_r[1]) begin
				swg_o_r <= swg_r;
				pre_o_r <= pre_r;
			end
			if (dup_r[0]) begin
				eq_o_r  <= eq_r;
				dcg_o_r <= dcg_r;
			end
		end
	end

	assign rc.differential_output_swing_out = swg_o_r;
	assign rc.preemph_out                   = pre_o_r;
	assign rc.eq_out                        = eq_o_r;
	assign rc.dcgain_out                    = dcg_o_r;
	assign afe_swing                        = swg_r;
	assign afe_preemph                      = pre_r;
	assign afe_eq                           = eq_r;
	assign afe_dcgain                       = dcg_r;
	assign afe_rate_div                     = rdv_r;

endmodule // rcfg_dev

// ===== rcfg_if.sv
// reconfiguration port between user fabric logic and the controller
// assumes both ends run on the same pclk
`timescale 1ns/1ps
interface rcfg_if;
	import rcfg_pkg::*;
	logic                   read;
	logic                   write;
	logic [1:0]             duplex_sel;
	logic [2:0]             op;
	logic [NCH*SWG_W-1:0]   swing_in;
	logic [NCH*PRE_W-1:0]   preemph_in;
	logic [NCH*EQ_W-1:0]    eq_in;
	logic [NCH*DCG_W-1:0]   dcgain_in;
	logic [NCH-1:0]         rate_div_in;
	logic                   powerdown;
	logic                   tx_digital_reset;
	logic                   rx_digital_reset;
	logic                   rx_analog_reset;
	logic                   busy;
	logic                   data_valid;
	logic                   rejected;
	logic                   freq_locked;
	logic [NCH*SWG_W-1:0]   differential_output_swing_out;
	logic [NCH*PRE_W-1:0]   preemph_out;
	logic [NCH*EQ_W-1:0]    eq_out;
	logic [NCH*DCG_W-1:0]   dcgain_out;

	modport dev (
		input  read, write, duplex_sel, op, swing_in, preemph_in, eq_in, dcgain_in,
		input  rate_div_in, powerdown, tx_digital_reset, rx_digital_reset, rx_analog_reset,
		output busy, data_valid, rejected, freq_locked,
		output differential_output_swing_out, preemph_out, eq_out, dcgain_out
	);
	modport usr (
		output read, write, duplex_sel, op, swing_in, preemph_in, eq_in, dcgain_in,
		output rate_div_in, powerdown, tx_digital_reset, rx_digital_reset, rx_analog_reset,
		input  busy, data_valid, rejected, freq_locked,
		input  differential_output_swing_out, preemph_out, eq_out, dcgain_out
	);
endinterface

// ===== rcfg_link_assertions.sv
// concurrent checks on the reconfiguration link between user end and controller
// assumes it sits beside rcfg_if and shares its pclk and presetn
`timescale 1ns/1ps
module rcfg_link_assertions
	import rcfg_pkg::*;
(
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 read,
	input wire logic                 write,
	input wire logic [2:0]           op,
	input wire logic                 powerdown,
	input wire logic                 rx_analog_reset,
	input wire logic                 busy,
	input wire logic                 data_valid,
	input wire logic                 rejected,
	input wire logic                 freq_locked,
	input wire logic [NCH*SWG_W-1:0] differential_output_swing_out
);
	// ****************************************
	// helper state
	// ****************************************
	logic [7:0] bcnt_r;
	logic       cal_done_r;
	logic       acc_rd;
	logic       req_bad;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcnt_r <= 8'h00;
		end else begin
			bcnt_r <= busy ? bcnt_r + 8'h01 : 8'h00;
		end
	end

	// latches one cycle late, so the first request slot after calibration is not judged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_done_r <= 1'b0;
		end else if (!busy && bcnt_r != 8'h00) begin
			cal_done_r <= 1'b1;
		end
	end

	assign acc_rd = read && !write && !busy && !powerdown && cal_done_r && op == 3'h0;
	assign req_bad = (read ^ write) && !busy && !powerdown && cal_done_r
		&& op >= 3'h3 && op <= 3'h5;

	// ****************************************
	// properties
	// ****************************************
	a_busy_length: assert property (!busy && bcnt_r != 8'h00 |-> bcnt_r == 8'h14)
		else $error("busy did not last 20 cycles");
	a_accept_busy: assert property (acc_rd |=> (busy && !data_valid) [*8])
		else $error("accepted read did not raise busy and clear data valid");
	a_read_done: assert property (acc_rd |-> ##21 (!busy && data_valid))
		else $error("read did not complete with data valid");
	a_valid_idle: assert property (data_valid |-> !busy)
		else $error("data valid while busy");
	a_swing_hold: assert property (data_valid && $past(data_valid)
		|-> $stable(differential_output_swing_out))
		else $error("readback changed while valid");
	a_busy_cause: assert property ($rose(busy) && cal_done_r |-> $past(read ^ write))
		else $error("busy rose without a request");
	a_unsup_reject: assert property (req_bad |=> rejected && !busy)
		else $error("unsupported request not rejected");
	a_lock_gate: assert property (rx_analog_reset |-> !freq_locked)
		else $error("lock shown while receiver analog reset");
	a_read_pulse: assert property (read |=> !read)
		else $error("read strobe longer than one cycle");
	a_idle_request: assert property (read || write |-> !busy)
		else $error("request issued while busy");
	a_cal_no_pdn: assert property (busy && !cal_done_r |-> !powerdown)
		else $error("power down during offset cancellation");
	a_cal_in_reset: assert property (busy && !cal_done_r |-> rx_analog_reset)
		else $error("receiver analog reset freed during offset cancellation");
endmodule // rcfg_link_assertions

// ===== rcfg_pkg.sv
// constants shared by the reconfiguration controller and its user end
// assumes one 50 MHz clock pclk and active-low asynchronous reset presetn
package rcfg_pkg;

	// ****************************************
	// geometry and timing
	// ****************************************
	localparam int NCH         = 2;
	localparam int SWG_W       = 3;
	localparam int PRE_W       = 3;
	localparam int EQ_W        = 3;
	localparam int DCG_W       = 2;
	localparam int CLK_NS      = 20;
	localparam int BUSY_CYC    = 20;
	localparam int PDN_MIN_NS  = 1000;
	localparam int PDN_CYC     = (PDN_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W       = 8;

	// ****************************************
	// request codes
	// ****************************************
	typedef enum logic [1:0] {
		DUP_RX_ONLY = 2'b01,
		DUP_TX_ONLY = 2'b10,
		DUP_BOTH    = 2'b11
	} rcfg_dup_t;

	typedef enum logic [2:0] {
		OP_ANALOG   = 3'h0,
		OP_CHAN_IF  = 3'h1,
		OP_RATE_DIV = 3'h2,
		OP_PATTERN  = 3'h3,
		OP_DIR_SW   = 3'h4,
		OP_BOND_SW  = 3'h5
	} rcfg_op_t;

	// ****************************************
	// apb register map of the user end
	// ****************************************
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_WDATA  = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_RDATA  = 8'h0c;

	localparam int C_RD   = 0;
	localparam int C_WR   = 1;
	localparam int C_OP   = 2;
	localparam int C_DUP  = 5;
	localparam int C_PDN  = 7;

	localparam int S_BUSY = 0;
	localparam int S_DV   = 1;
	localparam int S_REJ  = 2;
	localparam int S_LOCK = 3;
	localparam int S_PEND = 4;
	localparam int S_RUN  = 5;

	// settings word: swing, pre-emphasis, equalization, dc gain, rate divide
	localparam int F_SWG  = 0;
	localparam int F_PRE  = F_SWG + NCH * SWG_W;
	localparam int F_EQ   = F_PRE + NCH * PRE_W;
	localparam int F_DCG  = F_EQ + NCH * EQ_W;
	localparam int F_RDV  = F_DCG + NCH * DCG_W;
	localparam int F_TOP  = F_RDV + NCH;

	localparam logic [1:0] DUP_RST = 2'b10;

endpackage

// ===== rcfg_usr.sv
// user fabric end: apb registers drive reset sequencing and reconfiguration requests
// assumes the controller sits on the same pclk behind rcfg_if
`timescale 1ns/1ps
module rcfg_usr
	import rcfg_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	rcfg_if.usr               rc
);

	// ****************************************
	// state
	// ****************************************
	typedef enum logic [1:0] {
		SQ_PDN  = 2'b00,
		SQ_CAL  = 2'b01,
		SQ_LOCK = 2'b11,
		SQ_RUN  = 2'b10
	} rcfg_sq_t;

	rcfg_sq_t          sq_r;
	logic [CNT_W-1:0]  pcnt_r;
	logic              pend_rd_r;
	logic              pend_wr_r;
	logic [2:0]        op_r;
	logic [1:0]        dup_r;
	logic [F_TOP-1:0]  wdat_r;
	logic              rd_r;
	logic              wr_r;
	logic [31:0]       prdata_r;
	logic              wr_acc;
	logic              rd_acc;
	logic              mapped;
	logic              issue;

	// ****************************************
	// apb slave, zero wait states
	// ****************************************
	assign pready  = 1'b1;
	assign mapped  = (paddr == A_CTRL) || (paddr == A_WDATA) ||
	                 (paddr == A_STATUS) || (paddr == A_RDATA);
	assign pslverr = psel & penable & ~mapped;
	assign wr_acc  = psel & penable & pwrite & mapped;
	assign rd_acc  = psel & ~penable & ~pwrite;
	assign prdata  = prdata_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0;
		end else if (rd_acc) begin
			case (paddr)
				A_CTRL:   prdata_r <= 32'({rc.powerdown, dup_r, op_r, pend_wr_r, pend_rd_r});
				A_WDATA:  prdata_r <= 32'(wdat_r);
				A_STATUS: prdata_r <= 32'({sq_r == SQ_RUN, pend_rd_r | pend_wr_r,
				                          rc.freq_locked, rc.rejected, rc.data_valid,
				                          rc.busy});
				A_RDATA:  prdata_r <= 32'({rc.dcgain_out, rc.eq_out, rc.preemph_out,
				                          rc.differential_output_swing_out});
				default:  prdata_r <= 32'h0;
			endcase
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_r   <= OP_ANALOG;
			dup_r  <= DUP_RST;
			wdat_r <= '0;
		end else if (wr_acc && paddr == A_CTRL) begin
			op_r  <= pwdata[C_OP +: 3];
			dup_r <= pwdata[C_DUP +: 2];
		end else if (wr_acc && paddr == A_WDATA) begin
			wdat_r <= pwdata[F_TOP-1:0];
		end
	end

	// a read request wins over a write request posted in the same word
	assign issue = (sq_r == SQ_RUN) && !rc.busy && !rd_r && !wr_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_rd_r <= 1'b0;
			pend_wr_r <= 1'b0;
			rd_r      <= 1'b0;
			wr_r      <= 1'b0;
		end else begin
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			if (wr_acc && paddr == A_CTRL && pwdata[C_RD]) begin
				pend_rd_r <= 1'b1;
			end else if (issue && pend_rd_r) begin
				pend_rd_r <= 1'b0;
				rd_r      <= 1'b1;
			end
			if (wr_acc && paddr == A_CTRL && pwdata[C_WR]) begin
				pend_wr_r <= 1'b1;
			end else if (issue && pend_wr_r && !pend_rd_r) begin
				pend_wr_r <= 1'b0;
				wr_r      <= 1'b1;
			end
		end
	end

	assign rc.read        = rd_r;
	assign rc.write       = wr_r;
	assign rc.duplex_sel  = dup_r;
	assign rc.op          = op_r;
	assign rc.swing_in    = wdat_r[F_SWG +: NCH*SWG_W];
	assign rc.preemph_in  = wdat_r[F_PRE +: NCH*PRE_W];
	assign rc.eq_in       = wdat_r[F_EQ +: NCH*EQ_W];
	assign rc.dcgain_in   = wdat_r[F_DCG +: NCH*DCG_W];
	assign rc.rate_div_in = wdat_r[F_RDV +: NCH];

	// ****************************************
	// reset and power-down sequencer
	// ****************************************
	// power-down is only honoured between transactions so it never cuts a cancellation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sq_r   <= SQ_PDN;
			pcnt_r <= '0;
		end else begin
			case (sq_r)
				SQ_PDN: begin
					if (pcnt_r == CNT_W'(PDN_CYC - 1)) begin
						sq_r   <= SQ_CAL;
						pcnt_r <= '0;
					end else begin
						pcnt_r <= pcnt_r + CNT_W'(1);
					end
				end
				// the controller raises busy one edge after power-down falls,
				// so busy low is not trusted on the first cycle here
				SQ_CAL: begin
					if (pcnt_r == '0) begin
						pcnt_r <= CNT_W'(1);
					end else if (!rc.busy && !rc.powerdown) begin
						sq_r   <= SQ_LOCK;
						pcnt_r <= '0;
					end
				end
				SQ_LOCK: begin
					if (rc.freq_locked) begin
						sq_r <= SQ_RUN;
					end
				end
				SQ_RUN: begin
					if (wr_acc && paddr == A_CTRL && pwdata[C_PDN] && !rc.busy) begin
						sq_r <= SQ_PDN;
					end
				end
				default: sq_r <= SQ_PDN;
			endcase
		end
	end

	assign rc.powerdown        = (sq_r == SQ_PDN);
	assign rc.rx_analog_reset  = (sq_r == SQ_PDN) || (sq_r == SQ_CAL);
	assign rc.tx_digital_reset = (sq_r == SQ_PDN) || (sq_r == SQ_CAL);
	assign rc.rx_digital_reset = (sq_r != SQ_RUN);

endmodule // rcfg_usr

// ===== testbench.sv
// self-checking bench: apb drives the user end, which drives the controller
// assumes rcfg_pkg, rcfg_if, rcfg_usr, rcfg_dev and the checker are compiled first
`timescale 1ns/1ps
module testbench;
	import rcfg_pkg::*;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              cru_lock = 1'b0;
	logic [NCH-1:0]    tx_only = 2'b01;
	logic [5:0]        swg, pre, eq;
	logic [3:0]        dcg;
	logic [1:0]        rdv;
	logic              chk_on = 1'b0;
	logic [31:0]       rd_w, wd, wd2;
	logic [64:0]       expq[$];
	logic [64:0]       e;
	int                err_count = 0;
	int                checks = 0;

	rcfg_if rc_link ();
	rcfg_usr i_rcfg_usr (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rc(rc_link));
	rcfg_dev i_rcfg_dev (.pclk(pclk), .presetn(presetn), .rc(rc_link),
		.cru_locked_to_data(cru_lock), .chan_tx_only(tx_only), .afe_swing(swg),
		.afe_preemph(pre), .afe_eq(eq), .afe_dcgain(dcg), .afe_rate_div(rdv));
	rcfg_link_assertions i_chk (.pclk(pclk), .presetn(presetn), .read(rc_link.read),
		.write(rc_link.write), .op(rc_link.op), .powerdown(rc_link.powerdown),
		.rx_analog_reset(rc_link.rx_analog_reset), .busy(rc_link.busy),
		.data_valid(rc_link.data_valid), .rejected(rc_link.rejected),
		.freq_locked(rc_link.freq_locked),
		.differential_output_swing_out(rc_link.differential_output_swing_out));

	always #10 pclk = ~pclk;

	// ****************************************
	// compare, bus and closing tasks
	// ****************************************
	task automatic cmp(input string name, input logic [32:0] exp, input logic [32:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// queued expectations are judged by the monitor at the access edge
	always @(posedge pclk) begin
		if (psel && penable && pready && chk_on) begin
			e = expq.pop_front();
			cmp("apb read", {e[64], e[31:0]}, {pslverr, prdata & e[63:32]});
		end
	end

	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic c);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		chk_on <= c;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_w = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
		input logic er);
		expq.push_back({er, m, x & m});
		xfer(a, 1'b0, 32'h0, 1'b1);
	endtask

	// a few idle cycles first so a just-issued request shows as pending or busy
	task automatic poll(input logic [31:0] m, input logic [31:0] want);
		int n;
		n = 0;
		repeat (4) @(posedge pclk);
		do begin
			xfer(A_STATUS, 1'b0, 32'h0, 1'b0);
			n++;
		end while ((rd_w & m) !== want && n < 200);
		if ((rd_w & m) !== want) begin
			err_count++;
			$display("MISMATCH status poll expected %h seen %h", want, rd_w & m);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#(20 * 20000);
		err_count++;
		tally_and_finish();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		void'($urandom(44));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (90) @(posedge pclk);
		cru_lock <= 1'b1;
		poll(32'h20, 32'h20);
		chk(A_CTRL, 32'hff, 32'h40, 1'b0);
		chk(A_STATUS, 32'h3f, 32'h28, 1'b0);
		chk(8'h10, 32'hffffffff, 32'h0, 1'b1);
		$display("test reset done");
		wd = $urandom & 32'h3fffff;
		wr_go(wd, 32'h62);
		cmp("swing", {27'h0, wd[5:0]}, {27'h0, swg});
		cmp("preemph", {27'h0, wd[11:6]}, {27'h0, pre});
		cmp("eq", {27'h0, wd[17:12]}, {27'h0, eq});
		cmp("dcgain", {29'h0, wd[21:18]}, {29'h0, dcg});
		chk(A_STATUS, 32'h7, 32'h0, 1'b0);
		$display("test analog write done");
		xfer(A_CTRL, 1'b1, 32'h41, 1'b0);
		poll(32'h11, 32'h0);
		chk(A_RDATA, 32'hfff, wd, 1'b0);
		cmp("swing ch2", {30'h0, wd[5:3]}, {30'h0, rc_link.differential_output_swing_out[5:3]});
		chk(A_STATUS, 32'h7, 32'h2, 1'b0);
		xfer(A_CTRL, 1'b1, 32'h61, 1'b0);
		poll(32'h11, 32'h0);
		chk(A_RDATA, 32'h3fffff, wd, 1'b0);
		$display("test readback done");
		wd2 = $urandom & 32'h3fffff;
		wr_go(wd2, 32'h66);
		cmp("eq kept", {27'h0, wd[17:12]}, {27'h0, eq});
		cmp("swing new", {27'h0, wd2[5:0]}, {27'h0, swg});
		chk(A_STATUS, 32'h2, 32'h0, 1'b0);
		$display("test channel write done");
		for (int op = 3; op <= 5; op++) begin
			xfer(A_CTRL, 1'b1, 32'h41 | (op << 2), 1'b0);
			poll(32'h11, 32'h0);
			chk(A_STATUS, 32'h5, 32'h4, 1'b0);
		end
		$display("test unsupported done");
		wr_go(wd2 | 32'h400000, 32'h6a);
		chk(A_STATUS, 32'h5, 32'h4, 1'b0);
		cmp("rate div kept", 33'h0, {31'h0, rdv});
		wr_go(wd2 | 32'h800000, 32'h6a);
		chk(A_STATUS, 32'h5, 32'h0, 1'b0);
		cmp("rate div", 33'h2, {31'h0, rdv});
		$display("test rate divide done");
		tally_and_finish();
	end

	task automatic wr_go(input logic [31:0] d, input logic [31:0] ctrl);
		xfer(A_WDATA, 1'b1, d, 1'b0);
		xfer(A_CTRL, 1'b1, ctrl, 1'b0);
		poll(32'h11, 32'h0);
	endtask
endmodule // testbench
